// ==== rmu_global_status.sv ====
// Global command and status bank of the I/O and interrupt remapping unit.
// Assumes a register port master that never issues read and write at once,
// a flush agent that pulses done, and upstream logic that honours hold.
//
// Function
// [R1] Command bit 23: 0 blocks, 1 passes compat irqs
// [R2] Compat setting acts only remapping on, extended off
// [R3] Command register reads back no defined value
// [R4] Applied compat setting shown in status bit 23
// [R5] Flush write buffers before every invalidation
// [R6] Status bit 31 mirrors address remapping enable
// [R7] Bit 30 clears on root load, sets done
// [R8] Bit 29 clears on fault-log load, sets done
// [R9] Bit 28 mirrors advanced fault logging enable
// [R10] Bit 27 sets on flush command, clears done
// [R11] Status bit 26 mirrors queued invalidation enable
// [R12] Status bit 25 mirrors interrupt remapping enable
// [R13] Bit 24 clears on irq table load, sets done
// [R14] Bit 23: 0 blocked, 1 pass-through
// [R15] Status resets zero, ignores writes, low bits zero
// [R16] Command bit 24 one starts table load only
// [R17] Drain in-flight irqs, switch at boundaries only
// [R18] Command bit 26 enables queued invalidation
//
// Decided for this implementation: the plain strobed port.
`default_nettype none

module rmu_global_status
	import rmu_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	// Register port
	input  wire rmu_pkg::rmu_bus_req_s bus_req,
	output logic [31:0]               rdata,
	// Interrupt path
	input  wire rmu_pkg::rmu_irq_in_s  irq_in,
	input  wire logic                 ext_irq_mode,
	output rmu_pkg::rmu_irq_out_s      irq_out,
	// Write buffer flush and invalidation
	input  wire logic                 inval_req,
	input  wire logic                 wbuf_flush_done,
	output logic                      wbuf_flush_req,
	output logic                      inval_go,
	// Enables to the rest of the unit
	output rmu_pkg::rmu_en_s           en
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                xlate_on;
		logic [RMU_NPTR-1:0] ptr_state;
		logic                adv_fault_log;
		logic                wbuf_flush;
		logic                queued_inval;
		logic                irq_remap_on;
		logic                compat_pass;
		logic                ire_target;
		logic                ire_pend;
		logic                inv_pend;
		rmu_flush_e          fsm;
		logic                inval_go;
		logic                fwd;
		logic                drop;
		logic [31:0]         rdata;
	} rmu_main_s;

	rmu_main_s           s_ff;
	rmu_main_s           nxt_s;
	logic                cmd_wr;
	logic                sts_rd;
	logic [RMU_NPTR-1:0] ld_start;
	logic [RMU_NPTR-1:0] ld_done;
	logic                drain_idle;
	logic                wbf_cmd;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [RMU_AW-1:0] a,
	                             input logic [RMU_AW-1:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic [31:0] sts_word(input rmu_main_s st);
		logic [31:0] w;
		w = RMU_STS_RESET;
		w[RMU_B_XLATE] = st.xlate_on;
		w[RMU_B_ROOT]  = st.ptr_state[RMU_P_ROOT];
		w[RMU_B_FLOG]  = st.ptr_state[RMU_P_FLOG];
		w[RMU_B_AFL]   = st.adv_fault_log;
		w[RMU_B_WBF]   = st.wbuf_flush;
		w[RMU_B_QI]    = st.queued_inval;
		w[RMU_B_IRE]   = st.irq_remap_on;
		w[RMU_B_IRTP]  = st.ptr_state[RMU_P_IRTP];
		w[RMU_B_CFI]   = st.compat_pass;
		sts_word = w;
	endfunction

	assign cmd_wr  = bus_req.wr && hit(bus_req.addr, RMU_CMD_OFS);
	assign sts_rd  = bus_req.rd && hit(bus_req.addr, RMU_STS_OFS);
	assign wbf_cmd = cmd_wr && bus_req.wdata[RMU_B_WBF];

	// [R16] Load starts on one only
	assign ld_start[RMU_P_ROOT] = cmd_wr && bus_req.wdata[RMU_B_ROOT];
	assign ld_start[RMU_P_FLOG] = cmd_wr && bus_req.wdata[RMU_B_FLOG];
	assign ld_start[RMU_P_IRTP] = cmd_wr && bus_req.wdata[RMU_B_IRTP];

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < RMU_NPTR; gi++)
		begin : g_ld
			rmu_ptr_loader u_ld (
				.sys_clk (sys_clk),
				.sys_rst (sys_rst),
				.start   (ld_start[gi]),
				.done    (ld_done[gi])
			);
		end
	endgenerate

	rmu_irq_drain u_drain (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.flight_start (irq_in.flight_start),
		.flight_end   (irq_in.flight_end),
		.idle         (drain_idle)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_s          = s_ff;
		nxt_s.inval_go = 1'b0;
		nxt_s.fwd      = 1'b0;
		nxt_s.drop     = 1'b0;
		nxt_s.rdata    = RMU_RD_IDLE;

		// [R7] [R8] [R13] Pointer status
		for (int i = 0; i < RMU_NPTR; i++)
		begin
			if (ld_start[i])
				nxt_s.ptr_state[i] = 1'b0;
			else if (ld_done[i])
				nxt_s.ptr_state[i] = 1'b1;
		end

		// [R17] Switch only when drained
		if (s_ff.ire_pend && drain_idle && !irq_in.flight_start)
		begin
			nxt_s.irq_remap_on = s_ff.ire_target;
			nxt_s.ire_pend     = 1'b0;
		end

		if (cmd_wr)
		begin
			// [R6] Translation enable status
			nxt_s.xlate_on = bus_req.wdata[RMU_B_XLATE];
			// [R9] Advanced logging status
			if (RMU_HAS_AFL)
				nxt_s.adv_fault_log = bus_req.wdata[RMU_B_AFL];
			// [R18] [R11] Queued invalidation
			nxt_s.queued_inval = bus_req.wdata[RMU_B_QI];
			// [R12] Remap enable request
			nxt_s.ire_target = bus_req.wdata[RMU_B_IRE];
			nxt_s.ire_pend   = bus_req.wdata[RMU_B_IRE] != nxt_s.irq_remap_on;
			// [R4] [R14] Applied compat setting
			nxt_s.compat_pass = bus_req.wdata[RMU_B_CFI];
		end

		// [R5] [R10] Flush sequencing
		if (RMU_NEED_WBF)
		begin
			case (s_ff.fsm)
				FL_IDLE:
				begin
					if (wbf_cmd)
					begin
						nxt_s.wbuf_flush = 1'b1;
						nxt_s.fsm        = FL_CMD;
						nxt_s.inv_pend   = inval_req || s_ff.inv_pend;
					end
					else if (inval_req || s_ff.inv_pend)
					begin
						nxt_s.fsm      = FL_INV;
						nxt_s.inv_pend = 1'b0;
					end
				end
				FL_CMD:
				begin
					if (wbuf_flush_done)
					begin
						// A fresh command in the done cycle wins
						nxt_s.wbuf_flush = wbf_cmd;
						nxt_s.fsm        = wbf_cmd ? FL_CMD : FL_IDLE;
						if (inval_req || s_ff.inv_pend)
						begin
							nxt_s.inval_go = 1'b1;
							nxt_s.inv_pend = 1'b0;
						end
					end
					else if (inval_req)
						nxt_s.inv_pend = 1'b1;
				end
				FL_INV:
				begin
					if (wbf_cmd)
						nxt_s.wbuf_flush = 1'b1;
					if (inval_req)
						nxt_s.inv_pend = 1'b1;
					if (wbuf_flush_done)
					begin
						nxt_s.inval_go = 1'b1;
						nxt_s.fsm = nxt_s.wbuf_flush ? FL_CMD : FL_IDLE;
					end
				end
				default:
					nxt_s.fsm = FL_IDLE;
			endcase
		end
		else
			nxt_s.inval_go = inval_req;

		// [R1] [R2] Compat interrupt gate
		if (irq_in.compat_req)
		begin
			if (s_ff.irq_remap_on && !ext_irq_mode)
			begin
				nxt_s.fwd  = s_ff.compat_pass;
				nxt_s.drop = !s_ff.compat_pass;
			end
			else
				nxt_s.fwd = 1'b1;
		end

		// [R3] [R15] Reads: command and unmapped give zero
		if (sts_rd)
			nxt_s.rdata = sts_word(s_ff);
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			s_ff     <= '0;
			s_ff.fsm <= FL_IDLE;
		end
		else
			s_ff <= nxt_s;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rdata          = s_ff.rdata;
	assign irq_out.hold   = s_ff.ire_pend;
	assign irq_out.fwd    = s_ff.fwd;
	assign irq_out.drop   = s_ff.drop;
	assign wbuf_flush_req = (s_ff.fsm != FL_IDLE);
	assign inval_go       = s_ff.inval_go;
	assign en.xlate_on      = s_ff.xlate_on;
	assign en.adv_fault_log = s_ff.adv_fault_log;
	assign en.queued_inval  = s_ff.queued_inval;
	assign en.irq_remap_on  = s_ff.irq_remap_on;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	// Root status is due one load time plus one cycle after its command

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_root_cmd;
		cmd_wr && bus_req.wdata[RMU_B_ROOT];
	endsequence

	sequence s_root_cleared;
		!s_ff.ptr_state[RMU_P_ROOT] [*1];
	endsequence

	property p_cfi_apply;
		cmd_wr |=> s_ff.compat_pass == $past(bus_req.wdata[RMU_B_CFI]);
	endproperty
	a_cfi_apply: assert property (p_cfi_apply) // [R4]
		else $error("compat status not updated by command");

	property p_compat_block;
		irq_in.compat_req && s_ff.irq_remap_on && !ext_irq_mode
			&& !s_ff.compat_pass |=> irq_out.drop && !irq_out.fwd;
	endproperty
	a_compat_block: assert property (p_compat_block) // [R1]
		else $error("blocked compat irq was not dropped");

	property p_compat_ignore;
		irq_in.compat_req && (!s_ff.irq_remap_on || ext_irq_mode)
			|=> irq_out.fwd && !irq_out.drop;
	endproperty
	a_compat_ignore: assert property (p_compat_ignore) // [R2]
		else $error("compat setting applied outside its mode");

	property p_xlate;
		cmd_wr |=> en.xlate_on ==
			$past(bus_req.wdata[RMU_B_XLATE]);
	endproperty
	a_xlate: assert property (p_xlate) // [R6]
		else $error("translation status does not follow command");

	property p_root_load;
		s_root_cmd ##1 (!ld_start[RMU_P_ROOT]) [*6] |->
			s_ff.ptr_state[RMU_P_ROOT];
	endproperty
	a_root_load: assert property (p_root_load) // [R7]
		else $error("root pointer status not set after load");

	property p_root_clear;
		s_root_cmd |=> s_root_cleared;
	endproperty
	a_root_clear: assert property (p_root_clear) // [R7]
		else $error("root pointer status not cleared on command");

	property p_wbf_set;
		wbf_cmd |=> s_ff.wbuf_flush ##0 wbuf_flush_req;
	endproperty
	a_wbf_set: assert property (p_wbf_set) // [R10]
		else $error("flush status not set on command");

	property p_inval_after_flush;
		inval_go |-> $past(wbuf_flush_done) || !RMU_NEED_WBF;
	endproperty
	a_inval_after_flush: assert property (p_inval_after_flush) // [R5]
		else $error("invalidation released without a flush");

	property p_ire_boundary;
		$changed(s_ff.irq_remap_on) |-> $past(drain_idle)
			&& !$past(irq_in.flight_start);
	endproperty
	a_ire_boundary: assert property (p_ire_boundary) // [R17]
		else $error("remap enable switched with irqs in flight");

	property p_rsvd_zero;
		$past(sts_rd) |-> rdata[RMU_B_CFI-1:0] == '0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) // [R15]
		else $error("reserved status bits read nonzero");

	property p_qi;
		cmd_wr |=> en.queued_inval == $past(bus_req.wdata[RMU_B_QI]);
	endproperty
	a_qi: assert property (p_qi) // [R18]
		else $error("queued invalidation status wrong");

endmodule // rmu_global_status

`default_nettype wire

// ==== rmu_pkg.sv ====
// Constants, types and register map of the remap unit command/status bank.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
`default_nettype none

package rmu_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int          RMU_AW        = 12;
	localparam logic [11:0] RMU_CMD_OFS   = 12'h018;
	localparam logic [11:0] RMU_STS_OFS   = 12'h01c;
	localparam logic [31:0] RMU_STS_RESET = 32'h0000_0000;
	localparam logic [31:0] RMU_RD_IDLE   = 32'h0000_0000;

	// Bit positions shared by command and status
	localparam int RMU_B_XLATE = 31;
	localparam int RMU_B_ROOT  = 30;
	localparam int RMU_B_FLOG  = 29;
	localparam int RMU_B_AFL   = 28;
	localparam int RMU_B_WBF   = 27;
	localparam int RMU_B_QI    = 26;
	localparam int RMU_B_IRE   = 25;
	localparam int RMU_B_IRTP  = 24;
	localparam int RMU_B_CFI   = 23;

	// ------------------------------------------------------------------
	// Options and timing
	// ------------------------------------------------------------------
	localparam logic RMU_NEED_WBF = 1'b1;
	localparam logic RMU_HAS_AFL  = 1'b1;
	localparam int   RMU_CLK_NS   = 40;
	localparam int   RMU_LOAD_NS  = 200;
	localparam int   RMU_LOAD_CYC = (RMU_LOAD_NS + RMU_CLK_NS - 1) / RMU_CLK_NS;
	localparam int   RMU_LOAD_W   = 4;
	localparam logic [3:0] RMU_LOAD_CNT = 4'(RMU_LOAD_CYC);
	localparam logic [3:0] RMU_LOAD_ONE = 4'h1;
	localparam int   RMU_NPTR     = 3;
	localparam int   RMU_P_ROOT   = 0;
	localparam int   RMU_P_FLOG   = 1;
	localparam int   RMU_P_IRTP   = 2;
	localparam int   RMU_DRAIN_W  = 4;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {FL_IDLE, FL_CMD, FL_INV} rmu_flush_e;

	typedef struct packed {
		logic [RMU_AW-1:0] addr;
		logic [31:0]       wdata;
		logic              wr;
		logic              rd;
	} rmu_bus_req_s;

	typedef struct packed {
		logic compat_req;
		logic flight_start;
		logic flight_end;
	} rmu_irq_in_s;

	typedef struct packed {
		logic hold;
		logic fwd;
		logic drop;
	} rmu_irq_out_s;

	typedef struct packed {
		logic xlate_on;
		logic adv_fault_log;
		logic queued_inval;
		logic irq_remap_on;
	} rmu_en_s;

	typedef struct packed {
		logic                  busy;
		logic [RMU_LOAD_W-1:0] cnt;
	} rmu_ld_s;

	typedef struct packed {
		logic [RMU_DRAIN_W-1:0] cnt;
	} rmu_dr_s;

endpackage

`default_nettype wire

// ==== rmu_ptr_loader.sv ====
// Pointer load sequencer: a start pulse runs a fixed load time, then done.
// Assumes start is a one-cycle pulse; a new start restarts the load.
`default_nettype none

module rmu_ptr_loader
	import rmu_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// Control
	input  wire logic start,
	output logic      done
);

	rmu_ld_s s_ff;
	rmu_ld_s nxt_s;

	// Done is withheld on a restart so an old load never reports late
	assign done = s_ff.busy && (s_ff.cnt == RMU_LOAD_ONE) && !start;

	always_comb
	begin
		nxt_s = s_ff;
		if (start)
		begin
			nxt_s.busy = 1'b1;
			nxt_s.cnt  = RMU_LOAD_CNT;
		end
		else if (s_ff.busy)
		begin
			nxt_s.cnt = s_ff.cnt - RMU_LOAD_ONE;
			if (s_ff.cnt == RMU_LOAD_ONE)
				nxt_s.busy = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

endmodule // rmu_ptr_loader

`default_nettype wire

// ==== rmu_irq_drain.sv ====
// Counts interrupt requests in flight in the root complex.
// Assumes every end pulse matches an earlier start pulse.
`default_nettype none

module rmu_irq_drain
	import rmu_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// Requests
	input  wire logic flight_start,
	input  wire logic flight_end,
	output logic      idle
);

	rmu_dr_s s_ff;
	rmu_dr_s nxt_s;

	assign idle = (s_ff.cnt == '0);

	// Saturate rather than wrap: a wrap would fake an idle unit
	always_comb
	begin
		nxt_s = s_ff;
		if (flight_start && !flight_end && (s_ff.cnt != '1))
			nxt_s.cnt = s_ff.cnt + RMU_DRAIN_W'(1);
		else if (flight_end && !flight_start && (s_ff.cnt != '0))
			nxt_s.cnt = s_ff.cnt - RMU_DRAIN_W'(1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

endmodule // rmu_irq_drain

`default_nettype wire

// ==== rmu_global_status_tb.sv ====
// Self-checking bench for the remap unit command and status bank.
// Assumes the design package and the design files are compiled first.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rmu_pkg::*;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic                  sys_clk;
	logic                  sys_rst;
	rmu_pkg::rmu_bus_req_s bus_req;
	logic [31:0]           rdata;
	rmu_pkg::rmu_irq_in_s  irq_in;
	logic                  ext_irq_mode;
	rmu_pkg::rmu_irq_out_s irq_out;
	logic                  inval_req;
	logic                  wbuf_flush_done;
	logic                  wbuf_flush_req;
	logic                  inval_go;
	rmu_pkg::rmu_en_s      en;
	int                    mismatches;
	int                    num_checks;
	logic [31:0]           sts_exp;
	logic [31:0]           d;

	rmu_global_status rmu_global_status_inst (
		.sys_clk         (sys_clk),
		.sys_rst         (sys_rst),
		.bus_req         (bus_req),
		.rdata           (rdata),
		.irq_in          (irq_in),
		.ext_irq_mode    (ext_irq_mode),
		.irq_out         (irq_out),
		.inval_req       (inval_req),
		.wbuf_flush_done (wbuf_flush_done),
		.wbuf_flush_req  (wbuf_flush_req),
		.inval_go        (inval_go),
		.en              (en)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen,
	                   input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		@(negedge sys_clk);
		v = rdata;
	endtask

	// 0 compat, 1 flight start, 2 flight end, 3 inval, 4 flush done
	task automatic pulse(input int k);
		@(posedge sys_clk);
		case (k)
			0: irq_in.compat_req <= 1'b1;
			1: irq_in.flight_start <= 1'b1;
			2: irq_in.flight_end <= 1'b1;
			3: inval_req <= 1'b1;
			default: wbuf_flush_done <= 1'b1;
		endcase
		@(posedge sys_clk);
		irq_in <= '0;
		inval_req <= 1'b0;
		wbuf_flush_done <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic wait_ire(input logic exp);
		int i;
		for (i = 0; i < 20 && en.irq_remap_on !== exp; i++)
			@(negedge sys_clk);
		chk("irq_remap_on", {31'h0, en.irq_remap_on}, {31'h0, exp});
		if (en.irq_remap_on !== exp)
			complete_run();
	endtask

	task automatic sts(input string name);
		rd(RMU_STS_OFS, d);
		chk(name, d, sts_exp);
	endtask

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		mismatches = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		bus_req = '0;
		irq_in = '0;
		ext_irq_mode = 1'b0;
		inval_req = 1'b0;
		wbuf_flush_done = 1'b0;
		sts_exp = RMU_STS_RESET;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		sts("sts reset");
		rd(RMU_CMD_OFS, d);
		chk("cmd read", d, 32'h0000_0000);
		rd(12'h040, d);
		chk("unmapped read", d, RMU_RD_IDLE);
		// Pointer loads: clear on command, set after the load time
		for (int j = 0; j < 2; j++)
			for (int k = 0; k < RMU_NPTR; k++)
			begin
				int b;
				b = (k == 0) ? RMU_B_ROOT : (k == 1) ? RMU_B_FLOG : RMU_B_IRTP;
				wr(RMU_CMD_OFS, 32'h1 << b);
				sts_exp[b] = 1'b0;
				sts("ptr clear");
				repeat (RMU_LOAD_CYC + 3) @(posedge sys_clk);
				sts_exp[b] = 1'b1;
				sts("ptr set");
			end
		// Level enables follow every command write
		wr(RMU_CMD_OFS, 32'h9400_0000);
		sts_exp[31] = 1'b1;
		sts_exp[28] = 1'b1;
		sts_exp[26] = 1'b1;
		sts("enables on");
		chk("en", {28'h0, en}, 32'h0000_000e);
		wr(RMU_STS_OFS, 32'hffff_ffff);
		wr(12'h040, 32'hffff_ffff);
		sts("sts write");
		wr(RMU_CMD_OFS, 32'h0000_0000);
		sts_exp[31] = 1'b0;
		sts_exp[28] = 1'b0;
		sts_exp[26] = 1'b0;
		sts("enables off, ptr kept");
		chk("en off", {28'h0, en}, 32'h0000_0000);
		// Compat gating under interrupt remapping
		pulse(0);
		chk("fwd remap off", {31'h0, irq_out.fwd}, 32'h1);
		wr(RMU_CMD_OFS, 32'h1 << RMU_B_IRE);
		wait_ire(1'b1);
		pulse(0);
		chk("drop", {31'h0, irq_out.drop}, 32'h1);
		chk("no fwd", {31'h0, irq_out.fwd}, 32'h0);
		sts_exp[25] = 1'b1;
		sts("ire blocked");
		wr(RMU_CMD_OFS, 32'h0280_0000);
		pulse(0);
		chk("fwd pass", {31'h0, irq_out.fwd}, 32'h1);
		chk("no drop", {31'h0, irq_out.drop}, 32'h0);
		sts_exp[23] = 1'b1;
		sts("compat pass");
		wr(RMU_CMD_OFS, 32'h1 << RMU_B_IRE);
		ext_irq_mode <= 1'b1;
		pulse(0);
		chk("fwd ext mode", {31'h0, irq_out.fwd}, 32'h1);
		chk("no drop ext", {31'h0, irq_out.drop}, 32'h0);
		@(posedge sys_clk);
		ext_irq_mode <= 1'b0;
		sts_exp[23] = 1'b0;
		sts("compat block");
		// Disable waits for the in-flight request to drain
		pulse(1);
		wr(RMU_CMD_OFS, 32'h0000_0000);
		repeat (8) @(negedge sys_clk);
		chk("hold", {31'h0, irq_out.hold}, 32'h1);
		chk("ire kept", {31'h0, en.irq_remap_on}, 32'h1);
		pulse(2);
		wait_ire(1'b0);
		@(negedge sys_clk);
		chk("hold off", {31'h0, irq_out.hold}, 32'h0);
		// Flush with an invalidation waiting on it
		wr(RMU_CMD_OFS, 32'h1 << RMU_B_WBF);
		sts_exp[25] = 1'b0;
		sts_exp[27] = 1'b1;
		sts("flush set");
		chk("flush req", {31'h0, wbuf_flush_req}, 32'h1);
		pulse(3);
		chk("inval held", {31'h0, inval_go}, 32'h0);
		pulse(4);
		chk("inval go", {31'h0, inval_go}, 32'h1);
		sts_exp[27] = 1'b0;
		sts("flush clear");
		// Invalidation alone still flushes first
		pulse(3);
		chk("implicit flush", {31'h0, wbuf_flush_req}, 32'h1);
		chk("inval wait", {31'h0, inval_go}, 32'h0);
		pulse(4);
		chk("inval go 2", {31'h0, inval_go}, 32'h1);
		@(negedge sys_clk);
		chk("inval one cycle", {31'h0, inval_go}, 32'h0);
		chk("flush idle", {31'h0, wbuf_flush_req}, 32'h0);
		sts("flush idle sts");
		// Read data stand one cycle only, then fall back to idle
		@(negedge sys_clk);
		chk("rdata idle", rdata, RMU_RD_IDLE);
		complete_run();
	end

endmodule // tb

`default_nettype wire
